// File: gaic_pkg.sv
// Package with register offsets, field positions and reset values of the pin option logic.
package gaic_pkg;
    localparam int GAIC_NUM_PINS = 3;
    localparam int GAIC_NUM_EVENTS = 5;
    localparam logic [7:0] GAIC_OFS_EVENT_PINS = 8'h0E;
    localparam logic [7:0] GAIC_OFS_PIN_OPTION = 8'h0F;
    localparam int GAIC_EVT_LSB = 3;
    localparam int GAIC_BIT_IRQ_IGNORE = 7;
    localparam int GAIC_BIT_RSVD_LO = 6;
    localparam int GAIC_BIT_REASON_IGNORE = 5;
    localparam int GAIC_BIT_SPEED_IND = 4;
    localparam int GAIC_BIT_RSVD_HI = 3;
    localparam int GAIC_SPEED_PIN = 2;
    localparam logic [7:0] GAIC_RESET_EVENT_PINS = 8'h00;
    localparam logic [7:0] GAIC_RESET_PIN_OPTION = 8'h0F;
    localparam logic [2:0] GAIC_RESET_SYNC = 3'h0;
endpackage

// File: gaic_pin_if.sv
// Interface carrying pin drive and sampled levels between the core and the pad stage.
`timescale 1ns/1ps
interface gaic_pin_if #(parameter int N = 3);
    logic [N-1:0] drive_level;
    logic [N-1:0] drive_enable;
    logic [N-1:0] pin_level;
    modport core (output drive_level, output drive_enable, input pin_level);
    modport pads (input drive_level, input drive_enable, output pin_level);
endinterface

// File: gaic_pin_sync.sv
// Two-stage synchroniser for the general-purpose pin inputs.
`timescale 1ns/1ps
module gaic_pin_sync
    import gaic_pkg::*;
#(
    parameter int N = GAIC_NUM_PINS
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clk_en,
    // Pad side
    input wire logic [N-1:0] pin_in,
    // Core side
    gaic_pin_if.pads pins
);
    typedef struct packed
    {
        logic [N-1:0] first;
        logic [N-1:0] second;
    } gaic_sync_t;
    // A zero-width pin group cannot be built.
    if (N < 1)
    begin : g_width_check
        $error("Pin count must be at least one.");
    end
    gaic_sync_t state;
    gaic_sync_t next_state;
    always_comb
    begin
        next_state = state;
        if (clk_en)
        begin
            next_state.first = pin_in;
            next_state.second = state.first;
        end
    end
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            state <= '0;
        else
            state <= next_state;
    end
    assign pins.pin_level = state.second;
endmodule

// File: gaic_top.sv
// Pin option and event byte logic: general-purpose pins, speed indicator and drive options.
// Functional notes
// - Five user event bits go to host report.
// - Output pin drives the written level.
// - Pin value read returns actual pin level.
// - Option bit 7 ignores drive interrupt line.
// - Option bit 5 ignores interrupt reason register.
// - Option bit 4 puts speed on pin 2.
// - Low option bits: 0 output, 1 input.
// - Direction bits override the speed indicator.
`timescale 1ns/1ps
module gaic_top
    import gaic_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clk_en,
    // Configuration byte port
    input wire logic cfg_write,
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    output logic [7:0] cfg_rdata,
    // Status inputs
    input wire logic usb_high_speed,
    input wire logic drive_interrupt_line,
    // General-purpose pins
    input wire logic [gaic_pkg::GAIC_NUM_PINS-1:0] gpio_in,
    output logic [gaic_pkg::GAIC_NUM_PINS-1:0] gpio_out,
    output logic [gaic_pkg::GAIC_NUM_PINS-1:0] gpio_oe,
    // Results to the bridge engine
    output logic [gaic_pkg::GAIC_NUM_EVENTS-1:0] user_defined_event_bits,
    output logic drive_irq_used,
    output logic drive_irq_seen,
    output logic reason_ignore,
    output logic option_reserved_bad
);
    import gaic_pkg::*;

    gaic_pin_if #(.N(GAIC_NUM_PINS)) pins();

    gaic_pin_sync #(.N(GAIC_NUM_PINS)) u_sync
    (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .pin_in(gpio_in),
        .pins(pins.pads)
    );

    typedef struct packed
    {
        logic [7:0] event_pins;
        logic [7:0] pin_option;
        logic [7:0] rdata;
        logic [GAIC_NUM_PINS-1:0] out;
        logic [GAIC_NUM_PINS-1:0] oe;
        logic irq_used;
        logic irq_seen;
        logic rsvd_bad;
        logic [1:0] irq_sync;
    } gaic_state_t;

    gaic_state_t state;
    gaic_state_t next_state;

    // The event field sits right above the pin field, and together they fill one byte.
    if (GAIC_EVT_LSB != GAIC_NUM_PINS || GAIC_NUM_PINS + GAIC_NUM_EVENTS != 8)
    begin : g_layout_check
        $error("Event and pin fields do not fill one byte.");
    end

    // One decoder serves the write and the read path, so the two cannot disagree.
    function automatic logic [1:0] gaic_decode(input logic [7:0] addr);
        logic [1:0] sel;
        sel = 2'h0;
        if (addr == GAIC_OFS_EVENT_PINS)
            sel = 2'h1;
        else if (addr == GAIC_OFS_PIN_OPTION)
            sel = 2'h2;
        return sel;
    endfunction

    // A read returns the byte as it stood before the edge, so a write and a read of
    // one address in the same cycle still return the old value.
    function automatic logic [7:0] gaic_read(input logic [7:0] addr, input logic [7:0] evp,
                                             input logic [7:0] opt,
                                             input logic [GAIC_NUM_PINS-1:0] lvl);
        logic [7:0] val;
        val = 8'h00;
        if (gaic_decode(addr) == 2'h1)
            val = {evp[7:GAIC_EVT_LSB], lvl};
        else if (gaic_decode(addr) == 2'h2)
            val = opt;
        return val;
    endfunction

    always_comb
    begin
        next_state = state;
        if (clk_en)
        begin
            if (cfg_write && gaic_decode(cfg_addr) == 2'h1)
                next_state.event_pins = cfg_wdata;
            if (cfg_write && gaic_decode(cfg_addr) == 2'h2)
                next_state.pin_option = cfg_wdata;
            next_state.rdata = gaic_read(cfg_addr, state.event_pins, state.pin_option,
                                         pins.pin_level);
            for (int i = 0; i < GAIC_NUM_PINS; i++)
            begin
                next_state.oe[i] = ~next_state.pin_option[i];
                next_state.out[i] = next_state.event_pins[i];
            end
            // The indicator only replaces the level; the enable still follows direction.
            if (next_state.pin_option[GAIC_BIT_SPEED_IND])
                next_state.out[GAIC_SPEED_PIN] = ~usb_high_speed;
            next_state.irq_sync = {state.irq_sync[0], drive_interrupt_line};
            // Both flags follow the option as it stands after this edge, so they never disagree.
            next_state.irq_used = ~next_state.pin_option[GAIC_BIT_IRQ_IGNORE];
            // The drive line is asynchronous, so only the second stage is used.
            next_state.irq_seen = state.irq_sync[1] & ~next_state.pin_option[GAIC_BIT_IRQ_IGNORE];
            // Flags a loader that broke the fixed bits; the logic still runs.
            next_state.rsvd_bad = next_state.pin_option[GAIC_BIT_RSVD_LO] |
                                  ~next_state.pin_option[GAIC_BIT_RSVD_HI];
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state.event_pins <= GAIC_RESET_EVENT_PINS;
            state.pin_option <= GAIC_RESET_PIN_OPTION;
            state.rdata <= 8'h00;
            state.out <= '0;
            state.oe <= '0;
            state.irq_used <= 1'b0;
            state.irq_seen <= 1'b0;
            state.rsvd_bad <= 1'b0;
            state.irq_sync <= GAIC_RESET_SYNC[1:0];
        end
        else
            state <= next_state;
    end

    assign pins.drive_level = state.out;
    assign pins.drive_enable = state.oe;

    always_comb
    begin
        cfg_rdata = state.rdata;
        gpio_out = pins.drive_level;
        gpio_oe = pins.drive_enable;
        user_defined_event_bits = state.event_pins[7:GAIC_EVT_LSB];
        drive_irq_used = state.irq_used;
        drive_irq_seen = state.irq_seen;
        reason_ignore = state.pin_option[GAIC_BIT_REASON_IGNORE];
        option_reserved_bad = state.rsvd_bad;
    end
endmodule

// File: gaic_properties.sv
// Checker of the pin option and event byte behaviour.
`timescale 1ns/1ps
module gaic_properties
(
    // Watched ports
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic cfg_write,
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    input wire logic [2:0] gpio_out,
    input wire logic [2:0] gpio_oe,
    input wire logic [4:0] user_defined_event_bits,
    input wire logic drive_irq_used,
    input wire logic drive_irq_seen,
    input wire logic reason_ignore,
    input wire logic option_reserved_bad,
    input wire logic [7:0] cfg_rdata,
    input wire logic usb_high_speed,
    input wire logic drive_interrupt_line,
    input wire logic [2:0] gpio_in
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    logic we;
    logic wo;
    assign we = clk_en && cfg_write && cfg_addr == 8'h0E;
    assign wo = clk_en && cfg_write && cfg_addr == 8'h0F;
    AST_PIN_LEVEL: assert property (we |=> gpio_out[1:0] == $past(cfg_wdata[1:0]))
        else $error("Bad pin level.");
    AST_EVENTS: assert property (we |=> user_defined_event_bits == $past(cfg_wdata[7:3]))
        else $error("Bad event bits.");
    AST_DIRECTION: assert property (wo |=> gpio_oe == ~$past(cfg_wdata[2:0]))
        else $error("Bad direction.");
    AST_OE_HOLD: assert property (!wo |=> $stable(gpio_oe))
        else $error("Enable moved.");
    AST_IRQ_USE: assert property (wo |=> drive_irq_used != $past(cfg_wdata[7]))
        else $error("Bad line use.");
    AST_IRQ_SEEN: assert property (!drive_irq_used |-> !drive_irq_seen)
        else $error("Line seen.");
    AST_REASON: assert property (wo |=> reason_ignore == $past(cfg_wdata[5]))
        else $error("Bad reason flag.");
    AST_RSVD: assert property (wo |=> option_reserved_bad ==
        ($past(cfg_wdata[6]) || !$past(cfg_wdata[3])))
        else $error("Bad reserved flag.");
    AST_FREEZE: assert property (!clk_en |=> $stable(gpio_oe) && $stable(gpio_out))
        else $error("Pins moved while frozen.");
    AST_SPEED_LEVEL: assert property ((wo && cfg_wdata[4]) |=>
        gpio_out[2] == !$past(usb_high_speed))
        else $error("Bad speed level.");
    AST_READ_PINS: assert property ((clk_en [*3] ##0 (cfg_addr == 8'h0E)) |=>
        cfg_rdata[2:0] == $past(gpio_in, 3))
        else $error("Bad pin read.");
    AST_SEEN_LINE: assert property ((clk_en [*3] ##1 drive_irq_seen) |->
        $past(drive_interrupt_line, 3))
        else $error("Line seen without cause.");
    COV_OPT: cover property (wo);
    COV_SPEED: cover property (wo && cfg_wdata[4] && !cfg_wdata[2]);
    COV_EVT: cover property (we);
    COV_SEEN: cover property (drive_irq_seen);
endmodule
bind gaic_top gaic_properties chk (.*);

// File: gaic_pad_model.sv
// Model of the pads and the world beyond the pins.
`timescale 1ns/1ps
module gaic_pad_model
(
    // Pins
    input wire logic [2:0] gpio_out,
    input wire logic [2:0] gpio_oe,
    input wire logic [2:0] ext_level,
    output logic [2:0] gpio_in
);
    // A released pin shows what the outside drives.
    assign gpio_in = (gpio_out & gpio_oe) | (ext_level & ~gpio_oe);
endmodule

// File: gaic_tb.sv
// Self-checking bench of the pin option and event byte logic.
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; \
    $display("BAD %0t %h %h", $time, a, b); end end
module testbench;
    logic clk_sys = 0, reset_n = 0, clk_en = 1, cfg_write = 0;
    logic usb_high_speed = 0, drive_interrupt_line = 0;
    logic [7:0] cfg_addr = 8'h00, cfg_wdata = 8'h00, cfg_rdata;
    logic [2:0] ext = 3'h2, gpio_in, gpio_out, gpio_oe;
    logic [4:0] user_defined_event_bits;
    logic drive_irq_used, drive_irq_seen, reason_ignore, option_reserved_bad;
    int fail_count = 0, comparisons = 0, cyc = 0;
    initial forever #12.5 clk_sys = ~clk_sys;
    gaic_top dut (.*);
    gaic_pad_model pads (.gpio_out(gpio_out), .gpio_oe(gpio_oe), .ext_level(ext),
        .gpio_in(gpio_in));
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cfg_write = 1;
        cfg_addr = a;
        cfg_wdata = d;
        @(negedge clk_sys);
        cfg_write = 0;
        @(negedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        cfg_addr = a;
        repeat (4) @(negedge clk_sys);
        `CHK(cfg_rdata, e)
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            fail_count++;
            stop_test();
        end
    end
    initial
    begin
        repeat (16) @(negedge clk_sys);
        reset_n = 1;
        rd(8'h0F, 8'h0F);
        rd(8'h0E, 8'h02);
        wr(8'h0F, 8'h08);
        wr(8'h0E, 8'hAD);
        `CHK(gpio_oe, 3'h7)
        `CHK(gpio_out, 3'h5)
        `CHK(user_defined_event_bits, 5'h15)
        rd(8'h0E, 8'hAD);
        wr(8'h0F, 8'h0A);
        rd(8'h0E, 8'hAF);
        usb_high_speed = 1;
        wr(8'h0F, 8'h18);
        repeat (3) @(negedge clk_sys);
        `CHK(gpio_out[2], 1'b0)
        wr(8'h0F, 8'h1C);
        `CHK(gpio_oe, 3'h3)
        rd(8'h0E, 8'hA9);
        drive_interrupt_line = 1;
        wr(8'h0F, 8'hA8);
        repeat (4) @(negedge clk_sys);
        `CHK(gpio_out[2], 1'b1)
        `CHK({drive_irq_used, drive_irq_seen, reason_ignore}, 3'h1)
        wr(8'h0F, 8'h40);
        repeat (4) @(negedge clk_sys);
        `CHK({drive_irq_seen, option_reserved_bad}, 2'h3)
        wr(8'h10, 8'hFF);
        rd(8'h10, 8'h00);
        rd(8'h0F, 8'h40);
        clk_en = 0;
        wr(8'h0F, 8'h0F);
        `CHK(gpio_oe, 3'h7)
        clk_en = 1;
        rd(8'h0F, 8'h40);
        reset_n = 0;
        repeat (2) @(negedge clk_sys);
        `CHK({gpio_oe, gpio_out, user_defined_event_bits}, 11'h000)
        reset_n = 1;
        rd(8'h0F, 8'h0F);
        `CHK({drive_irq_used, drive_irq_seen, reason_ignore, option_reserved_bad}, 4'hC)
        drive_interrupt_line = 0;
        repeat (4) @(negedge clk_sys);
        `CHK(drive_irq_seen, 1'b0)
        stop_test();
    end
endmodule
